// *** hdl/epv_pkg.sv ***
// Package of constants and types for the exception priority and vectoring unit.
package epv_pkg;

	// Fixed handler addresses, the general offset and the reset value of the exception base.
	localparam logic [31:0] RESET_VECTOR = 32'hbfc0_0000;
	localparam logic [31:0] DEBUG_VECTOR_ROM = 32'hbfc0_0480;
	localparam logic [31:0] DEBUG_VECTOR_PROBE = 32'hbfc0_0200;
	localparam logic [31:0] GENERAL_OFFSET = 32'h0000_0180;
	localparam logic [31:0] EXCEPTION_BASE_RESET = 32'h9fc0_0000;

	// Cause codes written into the cause register.
	localparam logic [4:0] CAUSE_INT = 5'h00;
	localparam logic [4:0] CAUSE_LOAD_MISALIGN = 5'h04;
	localparam logic [4:0] CAUSE_FETCH_BUS_ERROR = 5'h06;
	localparam logic [4:0] CAUSE_SYSTEM_CALL_INSTRUCTION = 5'h08;
	localparam logic [4:0] CAUSE_BREAK = 5'h09;

	// Number of exception causes, and their index, highest priority first.
	localparam int NUM_CAUSES = 12;
	localparam int IDX_RESET = 0;
	localparam int IDX_SOFT_RESET = 1;
	localparam int IDX_SINGLE_STEP = 2;
	localparam int IDX_DEBUG_INT = 3;
	localparam int IDX_NMI = 4;
	localparam int IDX_INTERRUPT = 5;
	localparam int IDX_INSTR_BREAK = 6;
	localparam int IDX_LOAD_MISALIGN = 7;
	localparam int IDX_FETCH_BUS_ERROR = 8;
	localparam int IDX_DEBUG_BREAK = 9;
	localparam int IDX_SYSTEM_CALL_INSTRUCTION = 10;
	localparam int IDX_BREAK = 11;

	// Avalon-MM register word addresses (byte address = 4 * index).
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_CAUSE = 4'h1;
	localparam logic [3:0] REG_EXC_RETURN = 4'h2;
	localparam logic [3:0] REG_ERR_RETURN = 4'h3;
	localparam logic [3:0] REG_DBG_RETURN = 4'h4;
	localparam logic [3:0] REG_FAULT_ADDR = 4'h5;
	localparam logic [3:0] REG_EXC_BASE = 4'h6;
	localparam logic [3:0] REG_DEBUG = 4'h7;
	localparam logic [3:0] REG_DEBUG_CTRL = 4'h8;
	localparam logic [3:0] REG_IRQ_STATUS = 4'h9;
	localparam logic [3:0] REG_IRQ_MASK = 4'ha;

	// Field positions in the status word.
	localparam int ST_EXCEPTION_LEVEL = 1;
	localparam int ST_ERROR_LEVEL = 2;
	localparam int ST_NMI = 19;
	localparam int ST_SOFT_RESET = 20;
	localparam int ST_BOOT_VECTOR = 22;
	localparam int ST_PRIO_LEVEL_LSB = 10;
	// Field positions in the debug word.
	localparam int DB_SINGLE_STEP = 0;
	localparam int DB_BREAKPOINT = 1;
	localparam int DB_INSTR_BREAK = 4;
	localparam int DB_DEBUG_INT = 5;
	localparam int DB_DEBUG_MODE = 30;
	// Field positions in the debug control word.
	localparam int DC_PROBE_ENABLE = 15;
	localparam int DC_BREAK_REQUEST = 12;
	// Cause code and interrupt level positions in the cause word.
	localparam int CA_CODE_LSB = 2;
	localparam int CA_RIPL_LSB = 10;

	// Interrupt status bits: one per class of handler entry.
	localparam int IRQ_BITS = 3;
	localparam int IRQ_GENERAL = 0;
	localparam int IRQ_ERROR = 1;
	localparam int IRQ_DEBUG = 2;

	// Handler entry sequencer states.
	typedef enum logic [2:0] {
		EPV_IDLE = 3'b001,
		EPV_FLUSH = 3'b010,
		EPV_VECTOR = 3'b100
	} epv_state_e;

endpackage

// *** hdl/epv_exception_unit.sv ***
// Exception priority resolution, handler vectoring and exception register file.
// Overview of operation
// - Fixed priority: reset first, break last.
// - Master clear low: reset vector, boot, error.
// - Reset instruction: reset vector, boot, soft, error.
// - Single step: flag, probe-selected debug vector.
// - Break request bit raises debug interrupt.
// - Interrupt: update priority level, cause zero.
// - Instruction break: flag, probe-selected debug vector.
// - Load misalign: base plus 0x180, code 4.
// - Fetch bus error: base plus 0x180, code 6.
// - Breakpoint instruction: flag, debug vector.
// - System call: base plus 0x180, code 8.
// - Break instruction: base plus 0x180, code 9.
// - Save interrupted pc in exception return.
// - Error class saves pc in error return.
// - Debug class saves pc in debug return.
// - Capture faulting address of address exceptions.
// - Record last cause code.
`timescale 1ns/1ps

module epv_exception_unit (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Active-low master clear pin from the board, asynchronous to the clock.
	input wire logic i_master_clear_pin_n,
	// Pipeline cause requests, each held by the pipeline until acknowledged.
	input wire logic i_soft_reset,
	input wire logic i_single_step,
	input wire logic i_nmi,
	input wire logic i_interrupt,
	input wire logic [2:0] i_interrupt_level,
	input wire logic i_instr_break,
	input wire logic i_load_misalign,
	input wire logic i_fetch_bus_error,
	input wire logic i_debug_break_instruction,
	input wire logic i_system_call_instruction,
	input wire logic i_break_instruction,
	// Pc of the excepting instruction and the address that faulted.
	input wire logic [31:0] i_pc,
	input wire logic [31:0] i_bad_addr,
	// Avalon-MM slave.
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Pipeline control.
	output logic o_flush,
	output logic o_vector_valid,
	output logic [31:0] o_vector_addr,
	output logic [11:0] o_cause_ack,
	output logic o_irq
);

	// Two-stage synchroniser for the master clear pin.
	logic master_clear_meta_reg;
	logic master_clear_sync_reg;
	// Synchronised pin level one cycle earlier, for the falling-edge detector.
	logic master_clear_prev_reg;
	// Latched reset request: set when the pin falls, cleared by its own entry.
	logic reset_req_reg;
	// Pending cause vector, index 0 is highest priority.
	logic [11:0] pending;
	// One-hot winner of the priority race.
	logic [11:0] winner;
	// Cause captured at the start of an entry.
	logic [11:0] taken_reg;
	logic [31:0] taken_pc_reg;
	logic [31:0] taken_addr_reg;
	logic [2:0] taken_level_reg;
	epv_pkg::epv_state_e state_reg;
	// Architectural registers.
	logic [31:0] status_reg;
	logic [31:0] cause_reg;
	logic [31:0] exc_return_reg;
	logic [31:0] err_return_reg;
	logic [31:0] dbg_return_reg;
	logic [31:0] fault_addr_reg;
	logic [31:0] exc_base_reg;
	logic [31:0] debug_reg;
	logic [31:0] debug_ctrl_reg;
	logic [2:0] irq_status_reg;
	logic [2:0] irq_mask_reg;
	// Bus handshake: one wait cycle for every access.
	logic bus_ack_reg;
	logic bus_req;
	logic status_read;
	// Debug break request is a software bit; it clears itself when taken.
	logic dbg_break_req;

	// Picks the lowest-index set bit as a one-hot vector.
	function automatic logic [11:0] pick_first(input logic [11:0] req);
		logic [11:0] res;
		logic found;
		res = 12'h000;
		found = 1'b0;
		for (int i = 0; i < 12; i++) begin
			if (req[i] && !found) begin
				res[i] = 1'b1;
				found = 1'b1;
			end
		end
		return res;
	endfunction

	// Debug vector depends on whether a probe is attached.
	function automatic logic [31:0] debug_vector(input logic probe);
		return probe ? epv_pkg::DEBUG_VECTOR_PROBE : epv_pkg::DEBUG_VECTOR_ROM;
	endfunction

	// Synchronise the pin; only the second stage is read by logic.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			master_clear_meta_reg <= 1'b1;
			master_clear_sync_reg <= 1'b1;
		end else begin
			master_clear_meta_reg <= i_master_clear_pin_n;
			master_clear_sync_reg <= master_clear_meta_reg;
		end
	end

	// Reset request from the pin. Taken as a level it would enter twice: the pin stays
	// low in the synchroniser for two cycles after the far side sees the acknowledge,
	// long enough for the sequencer to return to idle and capture it again.
	// So the request is latched on the falling edge and cleared by its own entry.
	// A new fall in that same cycle wins, so a second press falling in that cycle is not lost.
	// Limitation: a pin held low for a long time gives one entry, not a stream.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			master_clear_prev_reg <= 1'b1;
			reset_req_reg <= 1'b0;
		end else begin
			master_clear_prev_reg <= master_clear_sync_reg;
			if (master_clear_prev_reg && !master_clear_sync_reg) begin
				// Falling edge of the synchronised pin.
				reset_req_reg <= 1'b1;
			end else if (state_reg == epv_pkg::EPV_FLUSH && taken_reg[epv_pkg::IDX_RESET]) begin
				// The reset entry has been made; the request is used up.
				reset_req_reg <= 1'b0;
			end
		end
	end

	assign dbg_break_req = debug_ctrl_reg[epv_pkg::DC_BREAK_REQUEST];

	// Gather causes; inputs stay up until acknowledged, so nothing is lost.
	always_comb begin
		pending = 12'h000;
		pending[epv_pkg::IDX_RESET] = reset_req_reg;
		pending[epv_pkg::IDX_SOFT_RESET] = i_soft_reset;
		pending[epv_pkg::IDX_SINGLE_STEP] = i_single_step;
		pending[epv_pkg::IDX_DEBUG_INT] = dbg_break_req;
		pending[epv_pkg::IDX_NMI] = i_nmi;
		pending[epv_pkg::IDX_INTERRUPT] = i_interrupt;
		pending[epv_pkg::IDX_INSTR_BREAK] = i_instr_break;
		pending[epv_pkg::IDX_LOAD_MISALIGN] = i_load_misalign;
		pending[epv_pkg::IDX_FETCH_BUS_ERROR] = i_fetch_bus_error;
		pending[epv_pkg::IDX_DEBUG_BREAK] = i_debug_break_instruction;
		pending[epv_pkg::IDX_SYSTEM_CALL_INSTRUCTION] = i_system_call_instruction;
		pending[epv_pkg::IDX_BREAK] = i_break_instruction;
		winner = pick_first(pending);
	end

	// Entry sequencer: capture, flush, then vector. Re-arbitrates after each entry.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state_reg <= epv_pkg::EPV_IDLE;
			taken_reg <= 12'h000;
			taken_pc_reg <= 32'h0000_0000;
			taken_addr_reg <= 32'h0000_0000;
			taken_level_reg <= 3'h0;
		end else begin
			unique case (state_reg)
				epv_pkg::EPV_IDLE: begin
					if (|pending) begin
						taken_reg <= winner;
						taken_pc_reg <= i_pc;
						taken_addr_reg <= i_bad_addr;
						taken_level_reg <= i_interrupt_level;
						state_reg <= epv_pkg::EPV_FLUSH;
					end
				end
				epv_pkg::EPV_FLUSH: begin
					state_reg <= epv_pkg::EPV_VECTOR;
				end
				epv_pkg::EPV_VECTOR: begin
					state_reg <= epv_pkg::EPV_IDLE;
				end
			endcase
		end
	end

	// Pipeline outputs: flush precedes the vector by one cycle.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_flush <= 1'b0;
			o_vector_valid <= 1'b0;
			o_vector_addr <= epv_pkg::RESET_VECTOR;
			o_cause_ack <= 12'h000;
		end else begin
			o_flush <= (state_reg == epv_pkg::EPV_IDLE) && (|pending);
			o_vector_valid <= (state_reg == epv_pkg::EPV_FLUSH);
			o_cause_ack <= (state_reg == epv_pkg::EPV_FLUSH) ? taken_reg : 12'h000;
			if (state_reg == epv_pkg::EPV_FLUSH) begin
				if (|taken_reg[epv_pkg::IDX_NMI:epv_pkg::IDX_RESET] &&
					!taken_reg[epv_pkg::IDX_SINGLE_STEP] && !taken_reg[epv_pkg::IDX_DEBUG_INT]) begin
					o_vector_addr <= epv_pkg::RESET_VECTOR;
				end else if (taken_reg[epv_pkg::IDX_SINGLE_STEP] || taken_reg[epv_pkg::IDX_DEBUG_INT]
					|| taken_reg[epv_pkg::IDX_INSTR_BREAK] || taken_reg[epv_pkg::IDX_DEBUG_BREAK]) begin
					o_vector_addr <= debug_vector(debug_ctrl_reg[epv_pkg::DC_PROBE_ENABLE]);
				end else begin
					// Interrupts also use the general entry in this block.
					o_vector_addr <= exc_base_reg + epv_pkg::GENERAL_OFFSET;
				end
			end
		end
	end

	// Status flags: set on entry, software may rewrite them through the bus.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			status_reg <= 32'h0000_0000;
		end else if (state_reg == epv_pkg::EPV_FLUSH) begin
			if (taken_reg[epv_pkg::IDX_RESET] || taken_reg[epv_pkg::IDX_SOFT_RESET]
				|| taken_reg[epv_pkg::IDX_NMI]) begin
				status_reg[epv_pkg::ST_BOOT_VECTOR] <= 1'b1;
				status_reg[epv_pkg::ST_ERROR_LEVEL] <= 1'b1;
				status_reg[epv_pkg::ST_SOFT_RESET] <= taken_reg[epv_pkg::IDX_SOFT_RESET];
				status_reg[epv_pkg::ST_NMI] <= taken_reg[epv_pkg::IDX_NMI];
			end
			if (taken_reg[epv_pkg::IDX_INTERRUPT]) begin
				status_reg[epv_pkg::ST_PRIO_LEVEL_LSB +: 3] <= taken_level_reg;
				status_reg[epv_pkg::ST_EXCEPTION_LEVEL] <= 1'b1;
			end
			if (|(taken_reg & 12'hd80)) begin
				status_reg[epv_pkg::ST_EXCEPTION_LEVEL] <= 1'b1;
			end
		end else if (bus_ack_reg && i_avs_write && i_avs_address == epv_pkg::REG_STATUS) begin
			status_reg <= i_avs_writedata;
		end
	end

	// Cause code and return pcs.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			cause_reg <= 32'h0000_0000;
			exc_return_reg <= 32'h0000_0000;
			err_return_reg <= 32'h0000_0000;
			dbg_return_reg <= 32'h0000_0000;
		end else if (state_reg == epv_pkg::EPV_FLUSH) begin
			exc_return_reg <= taken_pc_reg;
			if (|taken_reg[epv_pkg::IDX_SOFT_RESET:epv_pkg::IDX_RESET] ||
				taken_reg[epv_pkg::IDX_NMI]) begin
				err_return_reg <= taken_pc_reg;
			end
			if (|(taken_reg & 12'h24c)) begin
				dbg_return_reg <= taken_pc_reg;
			end
			if (taken_reg[epv_pkg::IDX_INTERRUPT]) begin
				cause_reg[epv_pkg::CA_CODE_LSB +: 5] <= epv_pkg::CAUSE_INT;
				cause_reg[epv_pkg::CA_RIPL_LSB +: 3] <= taken_level_reg;
			end else if (taken_reg[epv_pkg::IDX_LOAD_MISALIGN]) begin
				cause_reg[epv_pkg::CA_CODE_LSB +: 5] <= epv_pkg::CAUSE_LOAD_MISALIGN;
			end else if (taken_reg[epv_pkg::IDX_FETCH_BUS_ERROR]) begin
				cause_reg[epv_pkg::CA_CODE_LSB +: 5] <= epv_pkg::CAUSE_FETCH_BUS_ERROR;
			end else if (taken_reg[epv_pkg::IDX_SYSTEM_CALL_INSTRUCTION]) begin
				cause_reg[epv_pkg::CA_CODE_LSB +: 5] <= epv_pkg::CAUSE_SYSTEM_CALL_INSTRUCTION;
			end else if (taken_reg[epv_pkg::IDX_BREAK]) begin
				cause_reg[epv_pkg::CA_CODE_LSB +: 5] <= epv_pkg::CAUSE_BREAK;
			end
		end
	end

	// Faulting address of address-related exceptions.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			fault_addr_reg <= 32'h0000_0000;
		end else if (state_reg == epv_pkg::EPV_FLUSH &&
			(taken_reg[epv_pkg::IDX_LOAD_MISALIGN] || taken_reg[epv_pkg::IDX_FETCH_BUS_ERROR])) begin
			fault_addr_reg <= taken_addr_reg;
		end
	end

	// Debug flags: the taken debug cause sets its flag and debug mode.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			debug_reg <= 32'h0000_0000;
		end else if (state_reg == epv_pkg::EPV_FLUSH && (|(taken_reg & 12'h24c))) begin
			debug_reg[epv_pkg::DB_SINGLE_STEP] <= taken_reg[epv_pkg::IDX_SINGLE_STEP];
			debug_reg[epv_pkg::DB_DEBUG_INT] <= taken_reg[epv_pkg::IDX_DEBUG_INT];
			debug_reg[epv_pkg::DB_INSTR_BREAK] <= taken_reg[epv_pkg::IDX_INSTR_BREAK];
			debug_reg[epv_pkg::DB_BREAKPOINT] <= taken_reg[epv_pkg::IDX_DEBUG_BREAK];
			debug_reg[epv_pkg::DB_DEBUG_MODE] <= 1'b1;
		end else if (bus_ack_reg && i_avs_write && i_avs_address == epv_pkg::REG_DEBUG) begin
			debug_reg <= i_avs_writedata;
		end
	end

	// Software registers: exception base, debug control, interrupt mask.
	// The break request bit self-clears on entry; a software set in that same cycle wins.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			exc_base_reg <= epv_pkg::EXCEPTION_BASE_RESET;
			debug_ctrl_reg <= 32'h0000_0000;
			irq_mask_reg <= 3'h0;
		end else begin
			if (state_reg == epv_pkg::EPV_FLUSH && taken_reg[epv_pkg::IDX_DEBUG_INT]) begin
				debug_ctrl_reg[epv_pkg::DC_BREAK_REQUEST] <= 1'b0;
			end
			if (bus_ack_reg && i_avs_write) begin
				unique case (i_avs_address)
					epv_pkg::REG_EXC_BASE: exc_base_reg <= {i_avs_writedata[31:12], 12'h000};
					epv_pkg::REG_DEBUG_CTRL: debug_ctrl_reg <= i_avs_writedata;
					epv_pkg::REG_IRQ_MASK: irq_mask_reg <= i_avs_writedata[2:0];
					default: begin
					end
				endcase
			end
		end
	end

	// Avalon handshake: waitrequest high until the cycle after the request appears.
	assign bus_req = (i_avs_read || i_avs_write) && !bus_ack_reg;
	assign status_read = bus_ack_reg && i_avs_read && i_avs_address == epv_pkg::REG_IRQ_STATUS;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			bus_ack_reg <= 1'b0;
			o_avs_waitrequest <= 1'b1;
		end else begin
			bus_ack_reg <= bus_req;
			o_avs_waitrequest <= !bus_req;
		end
	end

	// Read data is registered with the acknowledge; unmapped words read zero.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_avs_readdata <= 32'h0000_0000;
		end else if (bus_req && i_avs_read) begin
			unique case (i_avs_address)
				epv_pkg::REG_STATUS: o_avs_readdata <= status_reg;
				epv_pkg::REG_CAUSE: o_avs_readdata <= cause_reg;
				epv_pkg::REG_EXC_RETURN: o_avs_readdata <= exc_return_reg;
				epv_pkg::REG_ERR_RETURN: o_avs_readdata <= err_return_reg;
				epv_pkg::REG_DBG_RETURN: o_avs_readdata <= dbg_return_reg;
				epv_pkg::REG_FAULT_ADDR: o_avs_readdata <= fault_addr_reg;
				epv_pkg::REG_EXC_BASE: o_avs_readdata <= exc_base_reg;
				epv_pkg::REG_DEBUG: o_avs_readdata <= debug_reg;
				epv_pkg::REG_DEBUG_CTRL: o_avs_readdata <= debug_ctrl_reg;
				epv_pkg::REG_IRQ_STATUS: o_avs_readdata <= {29'h0, irq_status_reg};
				epv_pkg::REG_IRQ_MASK: o_avs_readdata <= {29'h0, irq_mask_reg};
				default: o_avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// Sticky event bits; a read clears them but a same-cycle entry sets wins.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			irq_status_reg <= 3'h0;
			o_irq <= 1'b0;
		end else begin
			logic [2:0] ev;
			logic [2:0] nxt;
			ev = 3'h0;
			if (state_reg == epv_pkg::EPV_FLUSH) begin
				ev[epv_pkg::IRQ_GENERAL] = |(taken_reg & 12'hda0);
				ev[epv_pkg::IRQ_ERROR] = |(taken_reg & 12'h013);
				ev[epv_pkg::IRQ_DEBUG] = |(taken_reg & 12'h24c);
			end
			nxt = (status_read ? 3'h0 : irq_status_reg) | ev;
			irq_status_reg <= nxt;
			o_irq <= |(nxt & irq_mask_reg);
		end
	end

endmodule

// *** test/epv_exception_unit_monitor.sv ***
// Port checker for the exception priority and vectoring unit.
`timescale 1ns/1ps
module epv_exception_unit_monitor (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic o_avs_waitrequest,
	input wire logic o_flush,
	input wire logic o_vector_valid,
	input wire logic [31:0] o_vector_addr,
	input wire logic [11:0] o_cause_ack
);
	// One clock domain, so one default clock and one default disable.
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	// Acknowledge groups, one per handler class.
	logic rst_grp;
	logic dbg_grp;
	logic gen_grp;
	assign rst_grp = o_cause_ack[0] | o_cause_ack[1] | o_cause_ack[4];
	assign dbg_grp = o_cause_ack[2] | o_cause_ack[3] | o_cause_ack[6] | o_cause_ack[9];
	assign gen_grp = |{o_cause_ack[5], o_cause_ack[8:7], o_cause_ack[11:10]};
	a_flush_then_vector: assert property (o_flush |=> o_vector_valid)
		else $error("flush not followed by vector");
	a_ack_one_hot: assert property (o_vector_valid |-> $onehot(o_cause_ack))
		else $error("entry acknowledged more or less than one cause");
	a_ack_with_vector: assert property (|o_cause_ack |-> o_vector_valid)
		else $error("acknowledge without vector");
	a_reset_vector_addr: assert property (rst_grp |-> o_vector_addr == 32'hbfc0_0000)
		else $error("reset class took wrong vector");
	a_debug_vector_addr: assert property (dbg_grp |->
		o_vector_addr == 32'hbfc0_0480 || o_vector_addr == 32'hbfc0_0200)
		else $error("debug class took wrong vector");
	a_general_offset: assert property (gen_grp |-> o_vector_addr[11:0] == 12'h180)
		else $error("general class lacks the handler offset");
	a_entry_spacing: assert property (o_vector_valid |=> !o_vector_valid [*2])
		else $error("entries closer than three cycles");
	a_vector_stands: assert property (!o_vector_valid |-> $stable(o_vector_addr))
		else $error("vector address moved without an entry");
	a_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
		|-> ##[1:2] !o_avs_waitrequest)
		else $error("bus request not answered");
	a_bus_one_cycle: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low for more than a cycle");
	// Each handler class is entered at least once.
	c_reset_entry: cover property (o_vector_valid && rst_grp);
	c_debug_entry: cover property (o_vector_valid && dbg_grp);
	c_general_entry: cover property (o_vector_valid && gen_grp);
endmodule
bind epv_exception_unit epv_exception_unit_monitor i_mon (
	.i_ref_clk(i_ref_clk),
	.i_rst(i_rst),
	.i_avs_read(i_avs_read),
	.i_avs_write(i_avs_write),
	.o_avs_waitrequest(o_avs_waitrequest),
	.o_flush(o_flush),
	.o_vector_valid(o_vector_valid),
	.o_vector_addr(o_vector_addr),
	.o_cause_ack(o_cause_ack)
);

// *** test/epv_pipe_model.sv ***
// Pipeline and probe model holding each cause request until it is acknowledged.
`timescale 1ns/1ps
module epv_pipe_model (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [11:0] i_post,
	input wire logic [11:0] i_cause_ack,
	output logic [11:0] o_pend,
	output logic o_master_clear_pin_n
);
	// A request stays up until its own acknowledge, so a held-off one is never lost.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_pend <= 12'h000;
		end else begin
			o_pend <= (o_pend | i_post) & ~i_cause_ack;
		end
	end
	// The probe holds the pin low while its reset request is pending.
	assign o_master_clear_pin_n = ~o_pend[0];
endmodule

// *** test/exception_priority_vectoring_tb_top.sv ***
// Self-checking bench of the exception priority and vectoring unit.
`timescale 1ns/1ps
module exception_priority_vectoring_tb_top;
	// Row: cause index, class (0 general, 1 error, 2 debug), cause code, flag bit.
	typedef struct {
		int idx;
		int cls;
		logic [4:0] code;
		int fbit;
	} epv_row_s;
	// One row per cause, highest priority first.
	epv_row_s rows [12] = '{'{0, 1, 5'h00, 2}, '{1, 1, 5'h00, 20}, '{2, 2, 5'h00, 0},
		'{3, 2, 5'h00, 5}, '{4, 1, 5'h00, 19}, '{5, 0, 5'h00, 10}, '{6, 2, 5'h00, 4},
		'{7, 0, 5'h04, 1}, '{8, 0, 5'h06, 1}, '{9, 2, 5'h00, 1}, '{10, 0, 5'h08, 1},
		'{11, 0, 5'h09, 1}};
	localparam logic [31:0] GEN = epv_pkg::EXCEPTION_BASE_RESET + epv_pkg::GENERAL_OFFSET;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] post = 12'h000;
	logic [11:0] pend;
	logic pin_n;
	logic [31:0] pc = 32'h0000_1000;
	logic [31:0] bad = 32'h0000_2003;
	logic [3:0] addr = 4'h0;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] dc = 32'h0000_0000;
	logic [2:0] lvl = 3'h5;
	logic [31:0] rdata, vaddr, q, v, e;
	logic waitreq, flush, vvalid, irq;
	logic [11:0] ack, a;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	epv_row_s r;
	// Free-running clock, 10 ns period.
	always #5 clk = ~clk;
	epv_pipe_model i_pipe (.i_ref_clk(clk), .i_rst(rst), .i_post(post), .i_cause_ack(ack),
		.o_pend(pend), .o_master_clear_pin_n(pin_n));
	epv_exception_unit i_dut (.i_ref_clk(clk), .i_rst(rst), .i_master_clear_pin_n(pin_n),
		.i_soft_reset(pend[1]), .i_single_step(pend[2]), .i_nmi(pend[4]),
		.i_interrupt(pend[5]), .i_interrupt_level(lvl), .i_instr_break(pend[6]),
		.i_load_misalign(pend[7]), .i_fetch_bus_error(pend[8]),
		.i_debug_break_instruction(pend[9]), .i_system_call_instruction(pend[10]),
		.i_break_instruction(pend[11]), .i_pc(pc), .i_bad_addr(bad), .i_avs_address(addr),
		.i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata),
		.o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .o_flush(flush),
		.o_vector_valid(vvalid), .o_vector_addr(vaddr), .o_cause_ack(ack), .o_irq(irq));
	// Prints the counts and the verdict, then ends the run.
	task tally_and_finish;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Compares one word; an unknown bit never matches.
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One bus cycle, held until waitrequest is sampled low.
	task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d,
		output logic [31:0] rq);
		int k = 0;
		rd_en <= !w;
		wr_en <= w;
		addr <= ad;
		wdata <= d;
		do begin
			@(posedge clk);
			k++;
		end while (waitreq !== 1'b0 && k < 50);
		if (waitreq !== 1'b0) begin
			n_errors++;
			$display("wrong value at %0t: bus request never answered", $time);
		end
		rq = rdata;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
		@(posedge clk);
	endtask
	// Raises one cause; the debug interrupt comes from the break request bit.
	task fire(input int idx);
		if (idx == 3) begin
			bus(1'b1, epv_pkg::REG_DEBUG_CTRL, dc | 32'h0000_1000, q);
		end else begin
			post <= 12'h001 << idx;
			@(posedge clk);
			post <= 12'h000;
		end
	endtask
	// Waits, bounded, for a handler entry and takes its vector and acknowledge.
	task automatic wait_vec(output logic [31:0] va, output logic [11:0] aa);
		int k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (vvalid !== 1'b1 && k < 60);
		if (vvalid !== 1'b1) begin
			n_errors++;
			$display("wrong value at %0t: no handler entry", $time);
		end
		va = vaddr;
		aa = ack;
	endtask
	// Cuts a hang short.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	// Main sequence.
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(vaddr, epv_pkg::RESET_VECTOR);
		chk({31'h0, irq}, 32'h0);
		bus(1'b0, epv_pkg::REG_EXC_BASE, 32'h0, q);
		chk(q, epv_pkg::EXCEPTION_BASE_RESET);
		bus(1'b1, epv_pkg::REG_IRQ_MASK, 32'h0000_0007, q);
		bus(1'b1, epv_pkg::REG_DEBUG_CTRL, dc, q);
		for (int i = 0; i < 12; i++) begin
			r = rows[i];
			bus(1'b1, epv_pkg::REG_STATUS, 32'h0, q);
			bus(1'b1, epv_pkg::REG_DEBUG, 32'h0, q);
			pc <= pc + 32'h10;
			bad <= bad + 32'h10;
			fire(r.idx);
			wait_vec(v, a);
			e = (r.cls == 0) ? GEN : (r.cls == 1) ? epv_pkg::RESET_VECTOR : epv_pkg::DEBUG_VECTOR_ROM;
			chk(v, e);
			chk({20'h0, a}, 32'h1 << r.idx);
			chk({31'h0, irq}, 32'h1);
			bus(1'b0, epv_pkg::REG_IRQ_STATUS, 32'h0, q);
			chk(q, 32'h1 << r.cls);
			bus(1'b0, (r.cls == 2) ? epv_pkg::REG_DEBUG : epv_pkg::REG_STATUS, 32'h0, q);
			chk((q >> r.fbit) & 32'h1, 32'h1);
			chk({31'h0, irq}, 32'h0);
			bus(1'b0, epv_pkg::REG_EXC_RETURN, 32'h0, q);
			chk(q, pc);
			if (r.cls != 0) begin
				bus(1'b0, (r.cls == 1) ? epv_pkg::REG_ERR_RETURN : epv_pkg::REG_DBG_RETURN, 32'h0, q);
				chk(q, pc);
			end else begin
				bus(1'b0, epv_pkg::REG_CAUSE, 32'h0, q);
				chk({27'h0, q[6:2]}, {27'h0, r.code});
			end
			if (r.idx == 7 || r.idx == 8) begin
				bus(1'b0, epv_pkg::REG_FAULT_ADDR, 32'h0, q);
				chk(q, bad);
			end
		end
		// Three causes at once come out one by one, highest first.
		post <= 12'hc80;
		@(posedge clk);
		post <= 12'h000;
		for (int k = 0; k < 3; k++) begin
			wait_vec(v, a);
			chk({20'h0, a}, (k == 0) ? 32'h80 : (k == 1) ? 32'h400 : 32'h800);
		end
		// An interrupt at a new level overwrites the code and level left before it.
		lvl <= 3'h3;
		fire(5);
		wait_vec(v, a);
		chk(v, GEN);
		bus(1'b0, epv_pkg::REG_CAUSE, 32'h0, q);
		chk({27'h0, q[6:2]}, 32'h0);
		chk({29'h0, q[12:10]}, 32'h3);
		bus(1'b0, epv_pkg::REG_STATUS, 32'h0, q);
		chk({29'h0, q[12:10]}, 32'h3);
		// With the probe enabled the debug vector moves.
		dc = 32'h0000_8000;
		bus(1'b1, epv_pkg::REG_DEBUG_CTRL, dc, q);
		for (int k = 2; k < 4; k++) begin
			fire(k);
			wait_vec(v, a);
			chk(v, epv_pkg::DEBUG_VECTOR_PROBE);
		end
		// A masked event still sets its status bit but keeps the line low.
		bus(1'b0, epv_pkg::REG_IRQ_STATUS, 32'h0, q);
		bus(1'b1, epv_pkg::REG_IRQ_MASK, 32'h0, q);
		fire(10);
		wait_vec(v, a);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		bus(1'b0, epv_pkg::REG_IRQ_STATUS, 32'h0, q);
		chk(q, 32'h1);
		// Unmapped reads give zero; read-only words ignore writes.
		bus(1'b0, 4'hf, 32'h0, q);
		chk(q, 32'h0);
		bus(1'b0, epv_pkg::REG_CAUSE, 32'h0, e);
		bus(1'b1, epv_pkg::REG_CAUSE, 32'hffff_ffff, q);
		bus(1'b0, epv_pkg::REG_CAUSE, 32'h0, q);
		chk(q, e);
		// A second reset in mid-run brings back the idle vector and clears the controls.
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(vaddr, epv_pkg::RESET_VECTOR);
		chk({31'h0, irq}, 32'h0);
		bus(1'b0, epv_pkg::REG_DEBUG_CTRL, 32'h0, q);
		chk(q, 32'h0);
		tally_and_finish();
	end
endmodule
